// ===== sideband_pkg.sv
package sideband_pkg;
    // synchroniser depth for asynchronous pins
    localparam int SyncStages = 2;
    // number of local interrupt pins
    localparam int IrqPins = 2;
    // pin index of the maskable / nonmaskable fallback
    localparam int MaskablePin = 0;
    localparam int NmiPin = 1;

    // synchronised asynchronous inputs, active high internally
    typedef struct packed {
        logic skipFpFault;
        logic softInit;
        logic [1:0] localIrq;
    } sync_in_t;

    // interrupt requests presented to the core
    typedef struct packed {
        logic maskableIrq;
        logic nmiIrq;
        logic [1:0] localIrqReq;
    } irq_out_t;

    // lock sequencer states
    typedef enum logic [1:0] {
        LockIdle,
        LockHeld
    } lock_state_t;
endpackage

// ===== sync_two_stage.sv
`timescale 1ns/1ps
// ----------------------------------------------------------------------------
// two-flop synchroniser, first stage read only by the second
// ----------------------------------------------------------------------------
module sync_two_stage #(
    parameter int Width = 1,
    parameter logic [Width-1:0] ResetVal = '0
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // asynchronous in, synchronised out
    input wire logic [Width-1:0] asyncIn,
    output logic [Width-1:0] syncOut
);
    logic [Width-1:0] meta_q; // first stage, may go metastable

    // both stages reset to the idle level
    always_ff @(posedge clk) begin
        if (rst) begin
            meta_q <= ResetVal;
            syncOut <= ResetVal;
        end else begin
            meta_q <= asyncIn;
            syncOut <= meta_q;
        end
    end
endmodule

// ===== error_init_lock_sideband.sv
`timescale 1ns/1ps
// Functional notes
// - assert internal fault output on detected error
// - issue halt transaction with internal fault
// - fault latched until reset, bus reinit, init
// - skip pin active: ignore pending fp error
// - skip pin inactive: fault on prior fp error
// - skip pin ignored when native enable set
// - soft init clears integer regs, keeps cache/fp
// - soft init restarts at configured reset vector
// - snoops serviced while soft init held
// - soft init at reset release runs self-test
// - controller off: pin0 maskable, pin1 nonmaskable
// - local irq pins sampled asynchronously
// - local irq controller enabled after reset
// - lock held first through last locked transaction
module error_init_lock_sideband
    import sideband_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // asynchronous pins, active low where named _n
    input wire logic skip_fp_fault_n,
    input wire logic softInitN,
    input wire logic [IrqPins-1:0] local_irq_pins,
    input wire logic bus_reinit_n,
    // core side status and events
    input wire logic internalErrorEvt,
    input wire logic fpErrorPending,
    input wire logic fpNonControlOp,
    input wire logic native_fp_fault_enable,
    input wire logic irqCtrlWrite,
    input wire logic irqCtrlEnableIn,
    input wire logic snoopReq,
    input wire logic lockedSeqStart,
    input wire logic lockedSeqEnd,
    // fault and halt outputs
    output logic internal_fault_n,
    output logic halt_transaction,
    // execution control outputs
    output logic fpExceptionReq,
    output logic intRegClear,
    output logic resetVectorJump,
    output logic builtin_self_test,
    output logic snoopAck,
    // interrupt outputs
    output logic local_irq_controller,
    output logic maskable_irq,
    output logic nmiReq,
    output logic [IrqPins-1:0] localIrqReq,
    // bus lock, active low
    output logic busLockN
);
    sync_in_t syncIn; // synchronised pins, active high
    logic reinitMeta_q; // bus reinit first stage
    logic reinit_q; // bus reinit synchronised, active high
    logic softInitPrev_q; // for soft init edge
    logic rstPrev_q; // reset seen last cycle
    logic softInitEdge; // soft init newly asserted
    logic strapMeta_q; // self-test strap first stage, not reset
    logic strapSync_q; // self-test strap synchronised, active high
    lock_state_t lockState_q;

    // ------------------------------------------------------------------------
    // synchronisers
    // ------------------------------------------------------------------------
    // skip, soft init and local irq pins go through the shared two-flop cell
    sync_two_stage #(
        .Width($bits(sync_in_t)),
        .ResetVal('0)
    ) u_sync (
        .clk(clk),
        .rst(rst),
        .asyncIn({~skip_fp_fault_n, ~softInitN, local_irq_pins}),
        .syncOut(syncIn)
    );

    // bus reinit is a bus-clock signal but crosses from the pad anyway
    always_ff @(posedge clk) begin
        if (rst) begin
            reinitMeta_q <= 1'b0;
            reinit_q <= 1'b0;
        end else begin
            reinitMeta_q <= ~bus_reinit_n;
            reinit_q <= reinitMeta_q;
        end
    end

    // edge detection only looks at synchronised levels
    always_ff @(posedge clk) begin
        if (rst) begin
            softInitPrev_q <= 1'b0;
            rstPrev_q <= 1'b1;
        end else begin
            softInitPrev_q <= syncIn.softInit;
            rstPrev_q <= 1'b0;
        end
    end
    assign softInitEdge = syncIn.softInit & ~softInitPrev_q;

    // strap synchroniser keeps running through reset so the level at release is known;
    // the shared cell is held in reset and would always report idle at that edge
    always_ff @(posedge clk) begin
        strapMeta_q <= ~softInitN;
        strapSync_q <= strapMeta_q;
    end

    // ------------------------------------------------------------------------
    // internal fault latch and halt transaction
    // ------------------------------------------------------------------------
    // fault sets on error and stays until reset, reinit or soft init
    always_ff @(posedge clk) begin
        if (rst) begin
            internal_fault_n <= 1'b1;
        end else if (internalErrorEvt) begin
            internal_fault_n <= 1'b0; // set wins over clear
        end else if (reinit_q || syncIn.softInit) begin
            internal_fault_n <= 1'b1;
        end
    end

    // one-cycle halt request on the first cycle of a new fault
    always_ff @(posedge clk) begin
        if (rst) begin
            halt_transaction <= 1'b0;
        end else begin
            halt_transaction <= internalErrorEvt & internal_fault_n;
        end
    end

    a_fault_sets: assert property (@(posedge clk) disable iff (rst)
        internalErrorEvt |=> !internal_fault_n) else $error("fault not latched");
    a_fault_holds: assert property (@(posedge clk) disable iff (rst)
        (!internal_fault_n && !reinit_q && !syncIn.softInit) |=> !internal_fault_n)
        else $error("fault dropped early");
    a_halt_pairs: assert property (@(posedge clk) disable iff (rst)
        halt_transaction |-> !internal_fault_n) else $error("halt without fault");

    // ------------------------------------------------------------------------
    // numeric error handling
    // ------------------------------------------------------------------------
    // native enable overrides the skip pin entirely
    always_ff @(posedge clk) begin
        if (rst) begin
            fpExceptionReq <= 1'b0;
        end else if (native_fp_fault_enable) begin
            fpExceptionReq <= fpNonControlOp & fpErrorPending;
        end else begin
            // skip pin masks the pending error else it faults
            fpExceptionReq <= fpNonControlOp & fpErrorPending & ~syncIn.skipFpFault;
        end
    end

    a_fp_skip: assert property (@(posedge clk) disable iff (rst)
        (syncIn.skipFpFault && !native_fp_fault_enable) |=> !fpExceptionReq)
        else $error("fp error not ignored");
    a_fp_fault: assert property (@(posedge clk) disable iff (rst)
        (fpNonControlOp && fpErrorPending && !syncIn.skipFpFault) |=> fpExceptionReq)
        else $error("fp error not raised");
    a_fp_native: assert property (@(posedge clk) disable iff (rst)
        (native_fp_fault_enable && fpNonControlOp && fpErrorPending) |=> fpExceptionReq)
        else $error("skip pin not overridden");

    // ------------------------------------------------------------------------
    // soft init, reset vector and self-test
    // ------------------------------------------------------------------------
    // integer clear pulses on init; cache and fp state have no clear path
    always_ff @(posedge clk) begin
        if (rst) begin
            intRegClear <= 1'b0;
            resetVectorJump <= 1'b0;
        end else begin
            intRegClear <= softInitEdge;
            resetVectorJump <= softInitPrev_q & ~syncIn.softInit;
        end
    end

    // self-test strap caught on the first cycle after reset release,
    // from the strap synchroniser that reset does not clear
    always_ff @(posedge clk) begin
        if (rst) begin
            builtin_self_test <= 1'b0;
        end else if (rstPrev_q) begin
            builtin_self_test <= strapSync_q;
        end
    end

    a_builtin_self_test_strap: assert property (@(posedge clk) disable iff (rst)
        rstPrev_q |=> (builtin_self_test == $past(strapSync_q))) else $error("self-test strap missed");

    // snoops answered regardless of soft init
    always_ff @(posedge clk) begin
        if (rst) begin
            snoopAck <= 1'b0;
        end else begin
            snoopAck <= snoopReq;
        end
    end

    a_snoop_init: assert property (@(posedge clk) disable iff (rst)
        (snoopReq && syncIn.softInit) |=> snoopAck) else $error("snoop dropped in init");
    a_init_clear: assert property (@(posedge clk) disable iff (rst)
        (syncIn.softInit && !softInitPrev_q) |=> intRegClear) else $error("no register clear");

    // ------------------------------------------------------------------------
    // local interrupt pins
    // ------------------------------------------------------------------------
    // controller enabled out of reset, software may switch it
    always_ff @(posedge clk) begin
        if (rst) begin
            local_irq_controller <= 1'b1;
        end else if (irqCtrlWrite) begin
            local_irq_controller <= irqCtrlEnableIn;
        end
    end

    // route pins by mode
    always_ff @(posedge clk) begin
        if (rst) begin
            maskable_irq <= 1'b0;
            nmiReq <= 1'b0;
            localIrqReq <= '0;
        end else if (local_irq_controller) begin
            maskable_irq <= 1'b0;
            nmiReq <= 1'b0;
            localIrqReq <= syncIn.localIrq;
        end else begin
            maskable_irq <= syncIn.localIrq[MaskablePin];
            nmiReq <= syncIn.localIrq[NmiPin];
            localIrqReq <= '0;
        end
    end

    a_irq_legacy: assert property (@(posedge clk) disable iff (rst)
        (!local_irq_controller && syncIn.localIrq[NmiPin]) |=> nmiReq)
        else $error("nmi fallback missed");

    // ------------------------------------------------------------------------
    // bus lock
    // ------------------------------------------------------------------------
    // lock held from first locked transaction to end of last
    always_ff @(posedge clk) begin
        if (rst) begin
            lockState_q <= LockIdle;
            busLockN <= 1'b1;
        end else begin
            case (lockState_q)
                LockIdle: begin
                    if (lockedSeqStart) begin
                        lockState_q <= LockHeld;
                        busLockN <= 1'b0;
                    end
                end
                LockHeld: begin
                    if (lockedSeqEnd) begin
                        lockState_q <= LockIdle;
                        busLockN <= 1'b1;
                    end
                end
                default: begin
                    lockState_q <= LockIdle;
                    busLockN <= 1'b1;
                end
            endcase
        end
    end

    a_lock_holds: assert property (@(posedge clk) disable iff (rst)
        (!busLockN && !lockedSeqEnd) |=> !busLockN) else $error("lock released early");
endmodule

// ===== chipset_partner.sv
`timescale 1ns/1ps
// ----------------------------------------------------------------------------
// core logic and priority agent on the far side
// ----------------------------------------------------------------------------
module chipset_partner (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // from the device
    input wire logic halt_transaction,
    input wire logic busLockN,
    // priority agent wish, from the bench
    input wire logic wantBus,
    // agent pins and observed state
    output logic priority_agent_request_n,
    output logic busTaken_q,
    output logic errorNmi_q
);
    // request pin follows the wish; ownership only while the request is out
    // and the lock is seen released, so a lock raised with the request still wins
    always_ff @(posedge clk) begin
        if (rst) begin
            priority_agent_request_n <= 1'b1;
            busTaken_q <= 1'b0;
        end else begin
            priority_agent_request_n <= !wantBus;
            busTaken_q <= wantBus && !priority_agent_request_n && busLockN;
        end
    end
    // a halt transaction is turned into a sticky external error
    always_ff @(posedge clk) begin
        if (rst) begin
            errorNmi_q <= 1'b0;
        end else begin
            errorNmi_q <= errorNmi_q | halt_transaction;
        end
    end
endmodule

// ===== error_init_lock_sideband_tb.sv
`timescale 1ns/1ps
module error_init_lock_sideband_tb;
    import sideband_pkg::*;
    // ------------------------------------------------------------------------
    // signals
    // ------------------------------------------------------------------------
    logic clk, rst, skip_fp_fault_n, softInitN, bus_reinit_n, internalErrorEvt, fpErrorPending;
    logic fpNonControlOp, native_fp_fault_enable, irqCtrlWrite, irqCtrlEnableIn, snoopReq;
    logic lockedSeqStart, lockedSeqEnd, internal_fault_n, halt_transaction, fpExceptionReq;
    logic intRegClear, resetVectorJump, builtin_self_test, snoopAck, local_irq_controller;
    logic maskable_irq, nmiReq, busLockN, wantBus, priority_agent_request_n, busTaken_q, errorNmi_q;
    logic [IrqPins-1:0] local_irq_pins, localIrqReq;
    int n_mismatch = 0;
    int comparisons = 0;
    error_init_lock_sideband u_dut (.clk(clk), .rst(rst), .skip_fp_fault_n(skip_fp_fault_n),
        .softInitN(softInitN), .local_irq_pins(local_irq_pins), .bus_reinit_n(bus_reinit_n),
        .internalErrorEvt(internalErrorEvt), .fpErrorPending(fpErrorPending), .fpNonControlOp(fpNonControlOp),
        .native_fp_fault_enable(native_fp_fault_enable), .irqCtrlWrite(irqCtrlWrite),
        .irqCtrlEnableIn(irqCtrlEnableIn), .snoopReq(snoopReq), .lockedSeqStart(lockedSeqStart),
        .lockedSeqEnd(lockedSeqEnd), .internal_fault_n(internal_fault_n), .halt_transaction(halt_transaction),
        .fpExceptionReq(fpExceptionReq), .intRegClear(intRegClear), .resetVectorJump(resetVectorJump),
        .builtin_self_test(builtin_self_test), .snoopAck(snoopAck), .local_irq_controller(local_irq_controller),
        .maskable_irq(maskable_irq), .nmiReq(nmiReq), .localIrqReq(localIrqReq), .busLockN(busLockN));
    chipset_partner u_partner (.clk(clk), .rst(rst), .halt_transaction(halt_transaction),
        .busLockN(busLockN), .wantBus(wantBus), .priority_agent_request_n(priority_agent_request_n),
        .busTaken_q(busTaken_q), .errorNmi_q(errorNmi_q));
    // 100 ns bus clock
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    // ------------------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------------------
    task automatic check(input logic [1:0] seen, input logic [1:0] exp);
        comparisons++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    // inputs move on falling edges only
    task automatic tick(input int n);
        repeat (n) @(negedge clk);
    endtask
    task automatic test_done;
        $display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
        if (n_mismatch == 0 && comparisons > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    // ------------------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------------------
    // strap held steady across release so the synchroniser sees it
    task automatic t_reset(input logic strapN);
        softInitN = strapN;
        rst = 1'b1;
        tick(2);
        rst = 1'b0;
        tick(3);
        check(builtin_self_test, !strapN);
        check(local_irq_controller, 1'b1);
        check({internal_fault_n, busLockN}, 2'b11);
        softInitN = 1'b1;
        tick(4);
    endtask
    // fault stays latched until bus reinit
    task automatic t_fault;
        internalErrorEvt = 1'b1;
        tick(1);
        check(internal_fault_n, 1'b0);
        check(halt_transaction, 1'b1);
        tick(1);
        internalErrorEvt = 1'b0;
        check(halt_transaction, 1'b0);
        tick(5);
        check(internal_fault_n, 1'b0);
        check(errorNmi_q, 1'b1);
        bus_reinit_n = 1'b0;
        tick(4);
        check(internal_fault_n, 1'b1);
        bus_reinit_n = 1'b1;
        tick(3);
    endtask
    // all four skip / native combinations with an error pending
    task automatic t_fp;
        for (int i = 0; i < 4; i++) begin
            skip_fp_fault_n = !i[0];
            native_fp_fault_enable = i[1];
            {fpErrorPending, fpNonControlOp} = 2'b11;
            tick(4);
            check(fpExceptionReq, i[1] | !i[0]);
            fpErrorPending = 1'b0;
            tick(2);
            check(fpExceptionReq, 1'b0);
        end
        skip_fp_fault_n = 1'b1;
        tick(4);
    endtask
    // soft init clears a fault, keeps snooping, restarts on release
    task automatic t_init;
        internalErrorEvt = 1'b1;
        tick(1);
        internalErrorEvt = 1'b0;
        softInitN = 1'b0;
        tick(3);
        check(intRegClear, 1'b1);
        snoopReq = 1'b1;
        tick(1);
        check(snoopAck, 1'b1);
        check(internal_fault_n, 1'b1);
        snoopReq = 1'b0;
        softInitN = 1'b1;
        tick(3);
        check(resetVectorJump, 1'b1);
        tick(2);
    endtask
    // pins as local inputs, then as maskable / nonmaskable
    task automatic t_irq;
        local_irq_pins = 2'b10;
        tick(3);
        check(localIrqReq, 2'b10);
        check(nmiReq, 1'b0);
        {irqCtrlWrite, irqCtrlEnableIn} = 2'b10;
        tick(1);
        irqCtrlWrite = 1'b0;
        check(local_irq_controller, 1'b0);
        tick(1);
        check({maskable_irq, nmiReq}, 2'b01);
        check(localIrqReq, 2'b00);
        local_irq_pins = 2'b01;
        tick(3);
        check({maskable_irq, nmiReq}, 2'b10);
    endtask
    // priority agent held off for the whole locked sequence
    task automatic t_lock;
        {wantBus, lockedSeqStart} = 2'b11;
        tick(1);
        lockedSeqStart = 1'b0;
        check({busLockN, busTaken_q}, 2'b00);
        tick(4);
        check({busLockN, busTaken_q}, 2'b00);
        check(priority_agent_request_n, 1'b0);
        lockedSeqEnd = 1'b1;
        tick(1);
        lockedSeqEnd = 1'b0;
        tick(1);
        check(busLockN, 1'b1);
        tick(1);
        check(busTaken_q, 1'b1);
        wantBus = 1'b0;
    endtask
    // ------------------------------------------------------------------------
    // main sequence and watchdog
    // ------------------------------------------------------------------------
    initial begin
        {skip_fp_fault_n, softInitN, bus_reinit_n, rst} = 4'hF;
        {internalErrorEvt, fpErrorPending, fpNonControlOp, native_fp_fault_enable} = 4'h0;
        {irqCtrlWrite, irqCtrlEnableIn, snoopReq, lockedSeqStart, lockedSeqEnd, wantBus} = 6'h00;
        local_irq_pins = 2'h0;
        @(negedge clk);
        t_reset(1'b0);
        t_reset(1'b1);
        t_fault;
        t_fp;
        t_init;
        t_irq;
        t_lock;
        test_done;
    end
    // the sequence needs about 100 cycles; allow far more
    initial begin
        #100000;
        n_mismatch++;
        test_done;
    end
endmodule
